// File: hw/gpc_defs.vh
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH

// Command codes, most significant byte first on the wire
`define GPC_CMD_START_PERIODIC 16'h21b1
`define GPC_CMD_READ_MEAS 16'hec05
`define GPC_CMD_STOP_PERIODIC 16'h3f86
`define GPC_CMD_SINGLE_SHOT 16'h219d
`define GPC_CMD_SINGLE_RHT 16'h2196

// Clock and time base
`define GPC_CLK_HZ 125000000
`define GPC_TICK_MS 1
`define GPC_CYC_PER_TICK ((`GPC_CLK_HZ / 1000) * `GPC_TICK_MS)

// Times in milliseconds
`define GPC_PERIOD_MS 5000
`define GPC_STOP_BUSY_MS 500
`define GPC_SINGLE_MS 5000
`define GPC_SINGLE_RHT_MS 50
`define GPC_READ_MAX_MS 1

// Checksum defaults
`define GPC_CRC_POLY 8'h07
`define GPC_CRC_INIT 8'h00

// Response layout
`define GPC_RESP_BYTES 9
`define GPC_RESP_BITS 72
`define GPC_PAD_BYTE 8'hff

`endif

// File: hw/gpc_ms_tick.v
`timescale 1ns/100ps
`default_nettype none
`include "gpc_defs.vh"

module gpc_ms_tick #(
   parameter CYCLES = `GPC_CYC_PER_TICK
) (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Tick out
   output reg tick
);

   reg [31:0] cnt;

   always @(posedge clk) begin
      if (!rstn) begin
         cnt <= 32'h0;
         tick <= 1'b0;
      end else if (cnt >= CYCLES - 1) begin
         cnt <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 32'h1;
         tick <= 1'b0;
      end
   end

endmodule // gpc_ms_tick

`default_nettype wire

// File: hw/gpc_crc8.v
`timescale 1ns/100ps
`default_nettype none
`include "gpc_defs.vh"

module gpc_crc8 #(
   parameter [7:0] POLY = `GPC_CRC_POLY,
   parameter [7:0] INIT = `GPC_CRC_INIT
) (
   // Word in
   input wire [15:0] word,
   // Checksum out
   output reg [7:0] crc
);

   integer i;

   // Bitwise checksum, most significant bit first
   always @* begin
      crc = INIT;
      for (i = 15; i >= 0; i = i - 1) begin
         if (crc[7] ^ word[i])
            crc = {crc[6:0], 1'b0} ^ POLY;
         else
            crc = {crc[6:0], 1'b0};
      end
   end

endmodule // gpc_crc8

`default_nettype wire

// File: hw/gpc_cmd_if.v
// What this block does
// - Code 21b1 starts periodic mode; buffer refreshed every 5 s; no response.
// - Code ec05 offers nine bytes: gas, temperature, humidity words within 1 ms.
// - Reading the results empties the buffer; one fetch per interval.
// - Result read with empty buffer is answered with NACK.
// - Host may end read with NACK and STOP after any byte; device stops.
// - First word is gas concentration in ppm, unscaled.
// - Second word: temperature = -45 + 175 * word / 2^16 degrees.
// - Third word: humidity = 100 * word / 2^16 percent.
// - Code 3f86 leaves periodic mode; commands ignored for 500 ms.
// - Single-shot variant takes 219d (5000 ms) and 2196 (50 ms).
`timescale 1ns/100ps
`default_nettype none
`include "gpc_defs.vh"

module gpc_cmd_if #(
   parameter CYC_PER_TICK = `GPC_CYC_PER_TICK,
   parameter PERIOD_MS = `GPC_PERIOD_MS,
   parameter STOP_BUSY_MS = `GPC_STOP_BUSY_MS,
   parameter SINGLE_MS = `GPC_SINGLE_MS,
   parameter SINGLE_RHT_MS = `GPC_SINGLE_RHT_MS,
   parameter SINGLE_SHOT_EN = 1,
   parameter [7:0] CRC_POLY = `GPC_CRC_POLY,
   parameter [7:0] CRC_INIT = `GPC_CRC_INIT
) (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Write phase from the bus target
   input wire wr_start,
   output wire wr_ack,
   input wire rx_valid,
   input wire [7:0] rx_data,
   // Read phase from the bus target
   input wire rd_start,
   output wire rd_ack,
   input wire tx_req,
   output reg tx_valid,
   output reg [7:0] tx_data,
   input wire mst_nack,
   input wire bus_stop,
   // Measurement core
   output reg meas_req,
   output reg meas_rht_only,
   input wire meas_valid,
   input wire [15:0] meas_co2,
   input wire [15:0] meas_temp,
   input wire [15:0] meas_rh,
   // Status
   output wire periodic_on,
   output wire data_ready,
   output wire busy
);

   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_PERIODIC = 4'h2;
   localparam [3:0] ST_STOPPING = 4'h4;
   localparam [3:0] ST_SINGLE = 4'h8;

   reg [3:0] state;
   reg [15:0] ms_cnt;
   reg [7:0] cmd_hi;
   reg byte_idx;
   reg in_write;
   reg rd_armed;
   reg rd_active;
   reg buf_valid;
   reg [15:0] buf_co2;
   reg [15:0] buf_temp;
   reg [15:0] buf_rh;
   reg [`GPC_RESP_BITS-1:0] resp;

   wire ms_tick;
   wire [15:0] cmd_code;
   wire cmd_done;
   wire [47:0] buf_words;
   wire [23:0] buf_crcs;

   gpc_ms_tick #(
      .CYCLES(CYC_PER_TICK)
   ) u_tick (
      .clk(clk),
      .rstn(rstn),
      .tick(ms_tick)
   );

   // One checksum per buffered word
   assign buf_words = {buf_co2, buf_temp, buf_rh};

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_crc
         gpc_crc8 #(
            .POLY(CRC_POLY),
            .INIT(CRC_INIT)
         ) u_crc (
            .word(buf_words[g*16 +: 16]),
            .crc(buf_crcs[g*8 +: 8])
         );
      end
   endgenerate

   // Status and handshake
   assign busy = (state == ST_STOPPING) || (state == ST_SINGLE);
   assign wr_ack = !busy;
   assign rd_ack = rd_armed && buf_valid && !busy;
   assign periodic_on = (state == ST_PERIODIC);
   assign data_ready = buf_valid;

   // Second command byte completes the code
   assign cmd_code = {cmd_hi, rx_data};
   assign cmd_done = rx_valid && in_write && byte_idx && !busy;

   // Command assembly
   always @(posedge clk) begin
      if (!rstn) begin
         cmd_hi <= 8'h00;
         byte_idx <= 1'b0;
         in_write <= 1'b0;
      end else if (wr_start) begin
         byte_idx <= 1'b0;
         in_write <= !busy;
      end else if (bus_stop || rd_start) begin
         in_write <= 1'b0;
      end else if (rx_valid && in_write) begin
         if (!byte_idx) begin
            cmd_hi <= rx_data;
            byte_idx <= 1'b1;
         end else begin
            in_write <= 1'b0;
         end
      end
   end

   // Mode machine and millisecond timer
   always @(posedge clk) begin
      if (!rstn) begin
         state <= ST_IDLE;
         ms_cnt <= 16'h0;
         meas_req <= 1'b0;
         meas_rht_only <= 1'b0;
      end else begin
         meas_req <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (cmd_done) begin
                  if (cmd_code == `GPC_CMD_START_PERIODIC) begin
                     state <= ST_PERIODIC;
                     ms_cnt <= PERIOD_MS[15:0];
                  end else if (cmd_code == `GPC_CMD_STOP_PERIODIC) begin
                     state <= ST_STOPPING;
                     ms_cnt <= STOP_BUSY_MS[15:0] + 16'h1;
                  end else if (SINGLE_SHOT_EN != 0 &&
                               cmd_code == `GPC_CMD_SINGLE_SHOT) begin
                     state <= ST_SINGLE;
                     ms_cnt <= SINGLE_MS[15:0];
                     meas_req <= 1'b1;
                     meas_rht_only <= 1'b0;
                  end else if (SINGLE_SHOT_EN != 0 &&
                               cmd_code == `GPC_CMD_SINGLE_RHT) begin
                     state <= ST_SINGLE;
                     ms_cnt <= SINGLE_RHT_MS[15:0];
                     meas_req <= 1'b1;
                     meas_rht_only <= 1'b1;
                  end
               end
            end
            ST_PERIODIC: begin
               // Codes outside the allowed set are dropped here
               if (cmd_done && cmd_code == `GPC_CMD_STOP_PERIODIC) begin
                  state <= ST_STOPPING;
                  ms_cnt <= STOP_BUSY_MS[15:0] + 16'h1;
               end else if (ms_tick) begin
                  if (ms_cnt <= 16'h1) begin
                     ms_cnt <= PERIOD_MS[15:0];
                     meas_req <= 1'b1;
                     meas_rht_only <= 1'b0;
                  end else begin
                     ms_cnt <= ms_cnt - 16'h1;
                  end
               end
            end
            ST_STOPPING, ST_SINGLE: begin
               if (ms_tick) begin
                  if (ms_cnt <= 16'h1) begin
                     state <= ST_IDLE;
                     ms_cnt <= 16'h0;
                  end else begin
                     ms_cnt <= ms_cnt - 16'h1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               ms_cnt <= 16'h0;
            end
         endcase
      end
   end

   // Result buffer
   always @(posedge clk) begin
      if (!rstn) begin
         buf_valid <= 1'b0;
         buf_co2 <= 16'h0;
         buf_temp <= 16'h0;
         buf_rh <= 16'h0;
      end else begin
         if (rd_start && rd_ack)
            buf_valid <= 1'b0;
         // New data wins over a same-cycle read-out clear
         if (meas_valid) begin
            buf_valid <= 1'b1;
            buf_co2 <= meas_co2;
            buf_temp <= meas_temp;
            buf_rh <= meas_rh;
         end
      end
   end

   // Read sequence
   always @(posedge clk) begin
      if (!rstn) begin
         rd_armed <= 1'b0;
         rd_active <= 1'b0;
         resp <= {`GPC_RESP_BITS{1'b0}};
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
      end else begin
         tx_valid <= 1'b0;
         if (cmd_done) begin
            rd_armed <= (cmd_code == `GPC_CMD_READ_MEAS);
         end else if (wr_start) begin
            rd_armed <= 1'b0;
         end
         if (rd_start) begin
            rd_armed <= 1'b0;
            rd_active <= rd_ack;
            if (rd_ack)
               resp <= {buf_co2, buf_crcs[23:16],
                        buf_temp, buf_crcs[15:8],
                        buf_rh, buf_crcs[7:0]};
         end else if (mst_nack || bus_stop) begin
            rd_active <= 1'b0;
         end else if (tx_req && rd_active) begin
            tx_data <= resp[`GPC_RESP_BITS-1 -: 8];
            tx_valid <= 1'b1;
            resp <= {resp[`GPC_RESP_BITS-9:0], `GPC_PAD_BYTE};
         end
      end
   end

endmodule // gpc_cmd_if

`default_nettype wire

// File: bench/gpc_cmd_if_props.sv
`timescale 1ns/100ps
`default_nettype none
module gpc_cmd_if_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Bus target side
   input wire logic wr_ack,
   input wire logic rd_start,
   input wire logic rd_ack,
   input wire logic tx_req,
   input wire logic tx_valid,
   input wire logic mst_nack,
   // Core and status
   input wire logic meas_valid,
   input wire logic data_ready,
   input wire logic periodic_on,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_busy_no_write: assert property (busy |-> !wr_ack)
      else $error("write address accepted while busy");
   a_busy_span: assert property ($rose(busy) |-> busy[*8])
      else $error("busy time too short");
   a_stop_idle: assert property ($fell(busy) |-> !periodic_on)
      else $error("periodic mode still on after busy");
   a_empty_nack: assert property (rd_start && !data_ready |-> !rd_ack)
      else $error("read acked with empty buffer");
   a_read_clears: assert property (rd_start && rd_ack && !meas_valid |=> !data_ready)
      else $error("buffer not emptied by read");
   a_fill_ready: assert property (meas_valid |=> data_ready)
      else $error("new data not flagged");
   a_tx_cause: assert property (tx_valid |-> $past(tx_req))
      else $error("byte sent without request");
   a_nack_quiet: assert property (mst_nack ##1 tx_req |=> !tx_valid)
      else $error("byte sent after host nack");
   c_read: cover property (rd_start && rd_ack);
   c_abort: cover property (mst_nack);
   c_busy_end: cover property ($fell(busy));
endmodule // gpc_cmd_if_props
bind gpc_cmd_if gpc_cmd_if_props props (.clk, .rstn, .wr_ack, .rd_start,
   .rd_ack, .tx_req, .tx_valid, .mst_nack, .meas_valid, .data_ready,
   .periodic_on, .busy);
`default_nettype wire

// File: bench/gpc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module gpc_host_model (
   // Clock
   input wire logic clk,
   // Strobes to the target
   output var logic wr_start,
   output var logic rx_valid,
   output var logic [7:0] rx_data,
   output var logic rd_start,
   output var logic tx_req,
   output var logic mst_nack,
   output var logic bus_stop,
   // Answers from the target
   input wire logic rd_ack,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data
);
   initial {wr_start, rx_valid, rx_data, rd_start} = '0;
   initial {tx_req, mst_nack, bus_stop} = '0;
   task automatic send(input logic [15:0] code);
      @(posedge clk);
      wr_start <= 1'b1;
      for (int i = 1; i >= 0; i--) begin
         @(posedge clk);
         wr_start <= 1'b0;
         rx_valid <= 1'b1;
         rx_data <= code[i*8 +: 8];
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      bus_stop <= 1'b1;
      @(posedge clk);
      bus_stop <= 1'b0;
   endtask
   // Results only through the result read
   task automatic start_read(output logic ack);
      @(posedge clk);
      rd_start <= 1'b1;
      #1 ack = rd_ack;
      @(posedge clk);
      rd_start <= 1'b0;
   endtask
   task automatic get_byte(output logic [7:0] b, output logic got);
      @(posedge clk);
      tx_req <= 1'b1;
      @(posedge clk);
      tx_req <= 1'b0;
      #1 got = tx_valid;
      b = tx_data;
   endtask
   // NACK, one more request, then STOP
   task automatic finish_read(output logic got);
      @(posedge clk);
      mst_nack <= 1'b1;
      @(posedge clk);
      mst_nack <= 1'b0;
      tx_req <= 1'b1;
      @(posedge clk);
      tx_req <= 1'b0;
      bus_stop <= 1'b1;
      #1 got = tx_valid;
      @(posedge clk);
      bus_stop <= 1'b0;
   endtask
endmodule // gpc_host_model
`default_nettype wire

// File: bench/gpc_cmd_if_test.sv
`timescale 1ns/100ps
`default_nettype none
module gpc_cmd_if_test;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic wr_start, rx_valid, rd_start, tx_req, mst_nack, bus_stop;
   logic [7:0] rx_data, tx_data;
   logic wr_ack, rd_ack, tx_valid, meas_req, meas_rht_only;
   logic periodic_on, data_ready, busy;
   logic meas_valid = 1'b0;
   logic [15:0] meas_co2 = 16'h01f4, meas_temp = 16'h6667, meas_rh = 16'h5eb9;
   int err_count = 0, samples_checked = 0;
   always #4 clk = ~clk;
   // Core answers each start one cycle later, fresh words each time
   always @(posedge clk) begin
      meas_valid <= meas_req;
      if (meas_valid) begin
         meas_co2 <= meas_co2 + 16'h0100;
         meas_temp <= meas_temp + 16'h0001;
         meas_rh <= ~meas_rh;
      end
   end
   gpc_cmd_if #(.CYC_PER_TICK(10), .PERIOD_MS(5), .STOP_BUSY_MS(3),
      .SINGLE_MS(4), .SINGLE_RHT_MS(2), .CRC_POLY(8'h31), .CRC_INIT(8'hff))
   dut (.clk, .rstn, .wr_start, .wr_ack, .rx_valid, .rx_data, .rd_start,
      .rd_ack, .tx_req, .tx_valid, .tx_data, .mst_nack, .bus_stop, .meas_req,
      .meas_rht_only, .meas_valid, .meas_co2, .meas_temp, .meas_rh,
      .periodic_on, .data_ready, .busy);
   gpc_host_model host (.clk, .wr_start, .rx_valid, .rx_data, .rd_start,
      .tx_req, .mst_nack, .bus_stop, .rd_ack, .tx_valid, .tx_data);
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wait_for(input logic on_busy, input logic v, input int n,
      output int k);
      for (k = 0; k < n && (on_busy ? busy : data_ready) !== v; k++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic t_periodic;
      logic ack, got, all;
      logic [71:0] r;
      int k;
      all = 1'b1;
      host.send(16'hec05);
      host.start_read(ack);
      check(ack, 1'b0);
      host.send(16'h21b1);
      check(periodic_on, 1'b1);
      wait_for(1'b0, 1'b1, 70, k);
      check(k > 41 && k < 52 && data_ready === 1'b1, 1'b1);
      host.send(16'hec05);
      host.start_read(ack);
      check(ack, 1'b1);
      for (int i = 8; i >= 0; i--) begin
         host.get_byte(r[i*8 +: 8], got);
         all &= got;
      end
      host.finish_read(got);
      check(all, 1'b1);
      check(r[71:56], 16'h01f4);
      check(r[47:32], 16'h6667);
      check(r[23:8], 16'h5eb9);
      check({r[55:48], r[31:24]}, 16'h33a2);
      check(r[7:0], 8'h3c);
      check(data_ready, 1'b0);
      host.send(16'hec05);
      host.start_read(ack);
      check(ack, 1'b0);
      wait_for(1'b0, 1'b1, 70, k);
      host.send(16'hec05);
      host.start_read(ack);
      check(ack, 1'b1);
      host.get_byte(r[7:0], got);
      check(r[7:0], 8'h02);
      host.finish_read(got);
      check(got, 1'b0);
   endtask
   task automatic t_stop;
      int k;
      host.send(16'h3f86);
      check(wr_ack, 1'b0);
      host.send(16'h21b1);
      wait_for(1'b1, 1'b0, 60, k);
      check(k > 24 && k < 35 && busy === 1'b0, 1'b1);
      check(periodic_on, 1'b0);
   endtask
   task automatic t_single;
      logic ack, got;
      int k;
      host.send(16'h2196);
      check({busy, meas_rht_only}, 2'b11);
      wait_for(1'b1, 1'b0, 60, k);
      check(k > 9 && k < 20 && busy === 1'b0, 1'b1);
      host.send(16'hec05);
      host.start_read(ack);
      check(ack, 1'b1);
      host.finish_read(got);
      check(got, 1'b0);
      check(data_ready, 1'b0);
      host.send(16'h219d);
      check({busy, meas_rht_only}, 2'b10);
      wait_for(1'b1, 1'b0, 80, k);
      check(k > 29 && k < 40 && data_ready === 1'b1, 1'b1);
   endtask
   task automatic t_reset;
      host.send(16'h21b1);
      check(periodic_on, 1'b1);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      check({periodic_on, data_ready, busy, wr_ack, tx_valid}, 5'h02);
   endtask
   initial begin
      #20000;
      err_count++;
      conclude;
   end
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_periodic;
      t_stop;
      t_single;
      t_reset;
      conclude;
   end
endmodule // gpc_cmd_if_test
`default_nettype wire
